// ===== rtl/periph_irq_regs.sv
// peripheral interrupt flag, enable and priority registers with request output
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module periph_irq_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [periph_irq_pkg::ADDR_W-1:0] addr,
	input wire logic [periph_irq_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [periph_irq_pkg::DATA_W-1:0] rdata_r,
	// serial port 2 buffer state
	input wire logic serial2_rx_full,
	input wire logic serial2_tx_empty,
	// timer 4 and capture/compare units 3 to 5
	input wire logic timer4_event,
	input wire logic [5:0] capcomp_mode,
	input wire logic [2:0] capcomp_capture,
	input wire logic [2:0] capcomp_match,
	// flags of the other groups and third priorities
	input wire logic [7:0] flags_first,
	input wire logic [7:0] flags_second,
	input wire logic [7:0] priorities_third,
	// device mode
	input wire logic mcu_mode,
	// requests to core
	output logic high_req_r,
	output logic low_req_r,
	output logic irq_r
);
	import periph_irq_pkg::*;

	logic [7:0] peripheral_flags_third_r;
	logic [7:0] peripheral_enables_first_r;
	logic [7:0] peripheral_enables_second_r;
	logic [7:0] peripheral_enables_third_r;
	logic [7:0] peripheral_priorities_first_r;
	logic [7:0] peripheral_priorities_second_r;
	logic [7:0] ctrl_r;
	logic [7:0] irq_status_r;
	logic [7:0] irq_mask_r;
	logic [7:0] flags3_nxt;
	logic [7:0] irq_status_nxt;
	logic [7:0] read_nxt;
	logic [7:0] hw_set;
	logic [7:0] irq_events;
	logic [2:0] cc_set;
	logic high_prev_r;
	logic low_prev_r;
	logic wr_flags3;
	logic wr_irq_status;
	logic priority_levels_enable;
	logic peripheral_group_enable;

	assign priority_levels_enable = ctrl_r[BIT_PLE];
	assign peripheral_group_enable = ctrl_r[BIT_PGE];
	assign wr_flags3 = wr && (addr == OFF_FLAGS3);
	assign wr_irq_status = wr && (addr == OFF_IRQ_STATUS);

	// ----------------------------------------
	// capture/compare event selection
	// ----------------------------------------
	capcomp_event_select u_cc_sel (
		.mode(capcomp_mode),
		.capture_event(capcomp_capture),
		.match_event(capcomp_match),
		.set_event(cc_set)
	);

	// ----------------------------------------
	// third flag register
	// ----------------------------------------
	always_comb begin
		hw_set = 8'h00;
		hw_set[BIT_TIMER4] = timer4_event;
		hw_set[UNITS-1:0] = cc_set;
		flags3_nxt = peripheral_flags_third_r & MASK_FLAGS3_SW;
		if (wr_flags3) begin
			flags3_nxt = wdata & MASK_FLAGS3_SW;
		end
		// set wins over a clearing write
		flags3_nxt = flags3_nxt | hw_set;
		flags3_nxt[BIT_SERIAL2_RX] = serial2_rx_full;
		flags3_nxt[BIT_SERIAL2_TX] = serial2_tx_empty;
		flags3_nxt = flags3_nxt & MASK_FLAGS3;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			peripheral_flags_third_r <= RST_FLAGS3;
		end else begin
			peripheral_flags_third_r <= flags3_nxt;
		end
	end

	// ----------------------------------------
	// enable registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			peripheral_enables_first_r <= RST_EN;
			peripheral_enables_second_r <= RST_EN;
			peripheral_enables_third_r <= RST_EN;
		end else if (wr) begin
			if (addr == OFF_EN1) begin
				peripheral_enables_first_r <= wdata & MASK_EN1;
			end
			if (addr == OFF_EN2) begin
				peripheral_enables_second_r <= wdata & MASK_EN2;
			end
			if (addr == OFF_EN3) begin
				peripheral_enables_third_r <= wdata & MASK_EN3;
			end
		end
	end

	// ----------------------------------------
	// priority registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			peripheral_priorities_first_r <= RST_PRI1;
			peripheral_priorities_second_r <= RST_PRI2;
		end else if (wr) begin
			if (addr == OFF_PRI1) begin
				peripheral_priorities_first_r <= wdata;
			end
			if (addr == OFF_PRI2) begin
				peripheral_priorities_second_r <= wdata & MASK_EN2;
			end
		end
	end

	// ----------------------------------------
	// mode control register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= RST_CTRL;
		end else if (wr && (addr == OFF_CTRL)) begin
			ctrl_r <= wdata & MASK_CTRL;
		end
	end

	// ----------------------------------------
	// request forming
	// ----------------------------------------
	request_former u_req (
		.clk(clk),
		.rst(rst),
		.flags({peripheral_flags_third_r, flags_second, flags_first}),
		.enables({peripheral_enables_third_r, peripheral_enables_second_r, peripheral_enables_first_r}),
		.priorities({priorities_third, peripheral_priorities_second_r, peripheral_priorities_first_r}),
		.priority_levels_enable(priority_levels_enable),
		.peripheral_group_enable(peripheral_group_enable),
		.mcu_mode(mcu_mode),
		.high_req_r(high_req_r),
		.low_req_r(low_req_r)
	);

	// ----------------------------------------
	// interrupt status, mask and output
	// ----------------------------------------
	always_comb begin
		irq_events = 8'h00;
		irq_events[BIT_ST_HIGH] = high_req_r & ~high_prev_r;
		irq_events[BIT_ST_LOW] = low_req_r & ~low_prev_r;
		irq_status_nxt = irq_status_r;
		if (wr_irq_status) begin
			irq_status_nxt = irq_status_nxt & ~wdata;
		end
		// new event wins over write-one-to-clear
		irq_status_nxt = (irq_status_nxt | irq_events) & MASK_IRQ;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			high_prev_r <= 1'b0;
			low_prev_r <= 1'b0;
			irq_status_r <= RST_IRQ;
		end else begin
			high_prev_r <= high_req_r;
			low_prev_r <= low_req_r;
			irq_status_r <= irq_status_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_r <= RST_IRQ;
		end else if (wr && (addr == OFF_IRQ_MASK)) begin
			irq_mask_r <= wdata & MASK_IRQ;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_status_r & irq_mask_r);
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb begin
		case (addr)
			OFF_FLAGS3: read_nxt = peripheral_flags_third_r & MASK_FLAGS3;
			OFF_EN1: read_nxt = peripheral_enables_first_r;
			OFF_EN2: read_nxt = peripheral_enables_second_r & MASK_EN2;
			OFF_EN3: read_nxt = peripheral_enables_third_r & MASK_EN3;
			OFF_PRI1: read_nxt = peripheral_priorities_first_r;
			OFF_PRI2: read_nxt = peripheral_priorities_second_r & MASK_EN2;
			OFF_CTRL: read_nxt = ctrl_r;
			OFF_IRQ_STATUS: read_nxt = irq_status_r;
			OFF_IRQ_MASK: read_nxt = irq_mask_r;
			default: read_nxt = READ_NONE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= READ_NONE;
		end else if (rd) begin
			rdata_r <= read_nxt;
		end else begin
			rdata_r <= READ_NONE;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_rx_follows;
		serial2_rx_full |=> peripheral_flags_third_r[BIT_SERIAL2_RX] ##1 !$past(serial2_rx_full)
			|| peripheral_flags_third_r[BIT_SERIAL2_RX] == $past(serial2_rx_full);
	endproperty
	a_rx_follows: assert property (p_rx_follows) else $error("receive flag does not follow buffer");

	property p_tx_follows;
		!serial2_tx_empty ##1 !serial2_tx_empty |-> !peripheral_flags_third_r[BIT_SERIAL2_TX];
	endproperty
	a_tx_follows: assert property (p_tx_follows) else $error("transmit flag high with full buffer");

	property p_timer4_sets;
		timer4_event |=> peripheral_flags_third_r[BIT_TIMER4];
	endproperty
	a_timer4_sets: assert property (p_timer4_sets) else $error("timer 4 event lost");

	property p_timer4_holds;
		peripheral_flags_third_r[BIT_TIMER4] && !wr_flags3 |=> peripheral_flags_third_r[BIT_TIMER4];
	endproperty
	a_timer4_holds: assert property (p_timer4_holds) else $error("timer 4 flag dropped alone");

	property p_capture_sets;
		capcomp_mode[1:0] == CC_CAPTURE && capcomp_capture[0] |=> peripheral_flags_third_r[0];
	endproperty
	a_capture_sets: assert property (p_capture_sets) else $error("capture did not set flag");

	property p_pwm_quiet;
		capcomp_mode[1:0] == CC_PWM && !peripheral_flags_third_r[0] && !wr_flags3
			|=> !peripheral_flags_third_r[0];
	endproperty
	a_pwm_quiet: assert property (p_pwm_quiet) else $error("flag set in pwm mode");

	property p_top_bits_zero;
		peripheral_flags_third_r[7:6] == 2'b00 && peripheral_enables_third_r[7:6] == 2'b00;
	endproperty
	a_top_bits_zero: assert property (p_top_bits_zero) else $error("unimplemented bits set");

	property p_group_gate;
		!priority_levels_enable && !peripheral_group_enable |=> !high_req_r && !low_req_r;
	endproperty
	a_group_gate: assert property (p_group_gate) else $error("request passed without group enable");

	property p_high_from_prio;
		priority_levels_enable && |(peripheral_flags_third_r & peripheral_enables_third_r & priorities_third)
			|=> high_req_r;
	endproperty
	a_high_from_prio: assert property (p_high_from_prio) else $error("high request missing");

	property p_prio_reset;
		$fell(rst) |-> peripheral_priorities_first_r == RST_PRI1 && peripheral_priorities_second_r == RST_PRI2;
	endproperty
	a_prio_reset: assert property (p_prio_reset) else $error("priority reset value wrong");

	property p_irq_level;
		##1 irq_r == $past(|(irq_status_r & irq_mask_r));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt output mismatch");

	c_timer4_cycle: cover property (timer4_event ##1 wr_flags3 ##1 !peripheral_flags_third_r[BIT_TIMER4]);
	c_high_req: cover property (priority_levels_enable && high_req_r);
	c_low_req: cover property (priority_levels_enable && low_req_r);
	c_irq: cover property ($rose(irq_r));
endmodule
`default_nettype wire

// ===== rtl/periph_irq_pkg.sv
// constants and types for peripheral interrupt flag, enable and priority bookkeeping
package periph_irq_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int UNITS = 3;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [3:0] OFF_FLAGS3 = 4'h0;
	localparam logic [3:0] OFF_EN1 = 4'h1;
	localparam logic [3:0] OFF_EN2 = 4'h2;
	localparam logic [3:0] OFF_EN3 = 4'h3;
	localparam logic [3:0] OFF_PRI1 = 4'h4;
	localparam logic [3:0] OFF_PRI2 = 4'h5;
	localparam logic [3:0] OFF_CTRL = 4'h6;
	localparam logic [3:0] OFF_IRQ_STATUS = 4'h7;
	localparam logic [3:0] OFF_IRQ_MASK = 4'h8;
	// ----------------------------------------
	// field positions and masks
	// ----------------------------------------
	localparam int BIT_SERIAL2_RX = 5;
	localparam int BIT_SERIAL2_TX = 4;
	localparam int BIT_TIMER4 = 3;
	localparam int BIT_PARALLEL = 7;
	localparam int BIT_PLE = 7;
	localparam int BIT_PGE = 6;
	localparam int BIT_ST_HIGH = 0;
	localparam int BIT_ST_LOW = 1;
	localparam logic [7:0] MASK_FLAGS3 = 8'h3F;
	localparam logic [7:0] MASK_FLAGS3_SW = 8'h0F;
	localparam logic [7:0] MASK_EN1 = 8'hFF;
	localparam logic [7:0] MASK_EN2 = 8'h5F;
	localparam logic [7:0] MASK_EN3 = 8'h3F;
	localparam logic [7:0] MASK_CTRL = 8'hC0;
	localparam logic [7:0] MASK_IRQ = 8'h03;
	localparam logic [7:0] MASK_NO_PARALLEL = 8'h7F;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FLAGS3 = 8'h00;
	localparam logic [7:0] RST_EN = 8'h00;
	localparam logic [7:0] RST_PRI1 = 8'hFF;
	localparam logic [7:0] RST_PRI2 = 8'h5F;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_IRQ = 8'h00;
	localparam logic [7:0] READ_NONE = 8'h00;
	// ----------------------------------------
	// capture/compare unit modes
	// ----------------------------------------
	typedef enum logic [1:0] {CC_OFF, CC_CAPTURE, CC_COMPARE, CC_PWM} capcomp_mode_t;

	// flag set condition of one capture/compare unit
	function automatic logic capcomp_set(input logic [1:0] mode, input logic cap, input logic match);
		case (capcomp_mode_t'(mode))
			CC_CAPTURE: capcomp_set = cap;
			CC_COMPARE: capcomp_set = match;
			default: capcomp_set = 1'b0;
		endcase
	endfunction
endpackage

// ===== rtl/capcomp_event_select.sv
// picks the flag set event of each capture/compare unit by its mode
`timescale 1ns/1ps
`default_nettype none
module capcomp_event_select (
	// unit events
	input wire logic [5:0] mode,
	input wire logic [2:0] capture_event,
	input wire logic [2:0] match_event,
	// flag set strobes
	output logic [2:0] set_event
);
	import periph_irq_pkg::*;

	always_comb begin
		for (int i = 0; i < UNITS; i++) begin
			set_event[i] = capcomp_set(mode[2*i +: 2], capture_event[i], match_event[i]);
		end
	end
endmodule
`default_nettype wire

// ===== rtl/request_former.sv
// forms high and low priority peripheral requests toward the core
`timescale 1ns/1ps
`default_nettype none
module request_former (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// flags, enables, priorities
	input wire logic [23:0] flags,
	input wire logic [23:0] enables,
	input wire logic [23:0] priorities,
	// mode controls
	input wire logic priority_levels_enable,
	input wire logic peripheral_group_enable,
	input wire logic mcu_mode,
	// requests
	output logic high_req_r,
	output logic low_req_r
);
	import periph_irq_pkg::*;

	logic [23:0] en_eff;
	logic [23:0] active;

	always_comb begin
		en_eff = enables;
		if (!mcu_mode) begin
			en_eff[BIT_PARALLEL] = 1'b0;
		end
		active = flags & en_eff;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			high_req_r <= 1'b0;
			low_req_r <= 1'b0;
		end else if (priority_levels_enable) begin
			high_req_r <= |(active & priorities);
			low_req_r <= |(active & ~priorities);
		end else begin
			high_req_r <= peripheral_group_enable & (|active);
			low_req_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/periph_source_model.sv
// peripheral side model: serial 2 buffers and timer 4 period event
`timescale 1ns/1ps
`default_nettype none
module periph_source_model #(
	parameter int PERIOD = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// buffer traffic
	input wire logic rx_arrive,
	input wire logic rx_read,
	input wire logic tx_write,
	input wire logic tx_sent,
	// timer 4 run
	input wire logic timer4_run,
	// source levels and events
	output logic rx_full_r,
	output logic tx_empty_r,
	output logic timer4_event_r
);
	logic [7:0] count_r;
	always_ff @(posedge clk) begin
		if (rst || rx_read) begin
			rx_full_r <= 1'b0;
		end else if (rx_arrive) begin
			rx_full_r <= 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst || tx_sent) begin
			tx_empty_r <= 1'b1;
		end else if (tx_write) begin
			tx_empty_r <= 1'b0;
		end
	end
	// single event pulse per period match
	always_ff @(posedge clk) begin
		if (rst || !timer4_run) begin
			count_r <= 8'h00;
			timer4_event_r <= 1'b0;
		end else if (count_r == 8'(PERIOD - 1)) begin
			count_r <= 8'h00;
			timer4_event_r <= 1'b1;
		end else begin
			count_r <= count_r + 8'h01;
			timer4_event_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the peripheral interrupt registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import periph_irq_pkg::*;
	localparam int T4_PERIOD = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [9:0] ev = 10'h000;
	logic t4_run = 1'b0;
	logic [5:0] capcomp_mode = 6'h00;
	logic [7:0] flags_first = 8'h00;
	logic [7:0] flags_second = 8'h00;
	logic [7:0] priorities_third = 8'h00;
	logic mcu_mode = 1'b0;
	logic [7:0] rdata_r;
	logic rx_full_r;
	logic tx_empty_r;
	logic timer4_event_r;
	logic high_req_r;
	logic low_req_r;
	logic irq_r;
	int n_fail = 0;
	int checked = 0;
	always #5 clk = ~clk;
	// ----
	// design and peripheral model
	// ----
	periph_source_model #(.PERIOD(T4_PERIOD)) u_src (.clk(clk), .rst(rst),
		.rx_arrive(ev[0]), .rx_read(ev[1]), .tx_write(ev[2]), .tx_sent(ev[3]),
		.timer4_run(t4_run), .rx_full_r(rx_full_r), .tx_empty_r(tx_empty_r),
		.timer4_event_r(timer4_event_r));
	periph_irq_regs u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_r(rdata_r), .serial2_rx_full(rx_full_r), .serial2_tx_empty(tx_empty_r),
		.timer4_event(timer4_event_r), .capcomp_mode(capcomp_mode), .capcomp_capture(ev[6:4]),
		.capcomp_match(ev[9:7]), .flags_first(flags_first), .flags_second(flags_second),
		.priorities_third(priorities_third), .mcu_mode(mcu_mode),
		.high_req_r(high_req_r), .low_req_r(low_req_r), .irq_r(irq_r));
	// ----
	// shared tasks
	// ----
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk($sformatf("offset %h", a), rdata_r, exp);
	endtask
	task automatic pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev[b] <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic req_chk(input logic hi, input logic lo);
		repeat (3) @(posedge clk);
		#1;
		chk("high request", {7'h00, high_req_r}, {7'h00, hi});
		chk("low request", {7'h00, low_req_r}, {7'h00, lo});
	endtask
	task automatic wait_irq(input logic lvl);
		int k = 0;
		#1;
		while (irq_r !== lvl && k < 10) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("irq line", {7'h00, irq_r}, {7'h00, lvl});
		if (irq_r !== lvl) give_verdict();
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset();
		rd_chk(OFF_FLAGS3, 8'h10);
		rd_chk(OFF_EN1, 8'h00);
		rd_chk(OFF_EN2, 8'h00);
		rd_chk(OFF_EN3, 8'h00);
		rd_chk(OFF_PRI1, 8'hFF);
		rd_chk(OFF_PRI2, 8'h5F);
		rd_chk(OFF_CTRL, 8'h00);
		rd_chk(4'hF, 8'h00);
		@(posedge clk);
		#1;
		chk("idle read data", rdata_r, 8'h00);
		$display("reset values done");
	endtask
	task automatic t_access();
		reg_wr(OFF_EN1, 8'hFF);
		reg_wr(OFF_EN2, 8'hFF);
		reg_wr(OFF_EN3, 8'hFF);
		reg_wr(OFF_PRI1, 8'h00);
		reg_wr(OFF_PRI2, 8'hFF);
		reg_wr(OFF_FLAGS3, 8'hC0);
		rd_chk(OFF_EN1, 8'hFF);
		rd_chk(OFF_EN2, 8'h5F);
		rd_chk(OFF_EN3, 8'h3F);
		rd_chk(OFF_PRI1, 8'h00);
		rd_chk(OFF_PRI2, 8'h5F);
		rd_chk(OFF_FLAGS3, 8'h10);
		$display("register access done");
	endtask
	task automatic t_serial();
		pulse(0);
		rd_chk(OFF_FLAGS3, 8'h30);
		pulse(1);
		rd_chk(OFF_FLAGS3, 8'h10);
		pulse(2);
		rd_chk(OFF_FLAGS3, 8'h00);
		pulse(3);
		rd_chk(OFF_FLAGS3, 8'h10);
		$display("serial flags done");
	endtask
	task automatic t_timer4();
		// flags must set with their enables off
		reg_wr(OFF_EN3, 8'h00);
		@(posedge clk);
		t4_run <= 1'b1;
		repeat (T4_PERIOD + 2) @(posedge clk);
		t4_run <= 1'b0;
		rd_chk(OFF_FLAGS3, 8'h18);
		repeat (5) @(posedge clk);
		rd_chk(OFF_FLAGS3, 8'h18);
		reg_wr(OFF_FLAGS3, 8'h00);
		rd_chk(OFF_FLAGS3, 8'h10);
		$display("timer 4 flag done");
	endtask
	task automatic t_capcomp();
		for (int u = 0; u < 3; u++) begin
			for (int m = 0; m < 4; m++) begin
				@(posedge clk);
				capcomp_mode <= 6'(m) << (2 * u);
				reg_wr(OFF_FLAGS3, 8'h00);
				pulse(4 + u);
				rd_chk(OFF_FLAGS3, 8'h10 | ((m == 1) ? 8'(1 << u) : 8'h00));
				reg_wr(OFF_FLAGS3, 8'h00);
				pulse(7 + u);
				rd_chk(OFF_FLAGS3, 8'h10 | ((m == 2) ? 8'(1 << u) : 8'h00));
			end
		end
		reg_wr(OFF_FLAGS3, 8'h00);
		$display("capture compare flags done");
	endtask
	task automatic t_requests();
		reg_wr(OFF_EN3, 8'h01);
		capcomp_mode <= 6'h01;
		pulse(4);
		reg_wr(OFF_CTRL, 8'h00);
		req_chk(1'b0, 1'b0);
		reg_wr(OFF_CTRL, 8'h40);
		req_chk(1'b1, 1'b0);
		reg_wr(OFF_CTRL, 8'h80);
		req_chk(1'b0, 1'b1);
		@(posedge clk);
		priorities_third <= 8'h01;
		req_chk(1'b1, 1'b0);
		reg_wr(OFF_EN3, 8'h00);
		req_chk(1'b0, 1'b0);
		@(posedge clk);
		flags_first <= 8'h80;
		reg_wr(OFF_EN1, 8'h80);
		reg_wr(OFF_PRI1, 8'hFF);
		req_chk(1'b0, 1'b0);
		@(posedge clk);
		mcu_mode <= 1'b1;
		req_chk(1'b1, 1'b0);
		reg_wr(OFF_PRI1, 8'h7F);
		req_chk(1'b0, 1'b1);
		@(posedge clk);
		flags_first <= 8'h00;
		flags_second <= 8'h40;
		reg_wr(OFF_EN2, 8'h40);
		req_chk(1'b1, 1'b0);
		reg_wr(OFF_PRI2, 8'h00);
		req_chk(1'b0, 1'b1);
		@(posedge clk);
		flags_second <= 8'h00;
		req_chk(1'b0, 1'b0);
		$display("request forming done");
	endtask
	task automatic t_irq();
		reg_wr(OFF_IRQ_MASK, 8'h00);
		reg_wr(OFF_IRQ_STATUS, 8'h03);
		rd_chk(OFF_IRQ_STATUS, 8'h00);
		@(posedge clk);
		flags_second <= 8'h40;
		repeat (4) @(posedge clk);
		rd_chk(OFF_IRQ_STATUS, 8'h02);
		chk("masked irq", {7'h00, irq_r}, 8'h00);
		reg_wr(OFF_IRQ_MASK, 8'h02);
		rd_chk(OFF_IRQ_MASK, 8'h02);
		wait_irq(1'b1);
		reg_wr(OFF_IRQ_STATUS, 8'h02);
		wait_irq(1'b0);
		rd_chk(OFF_IRQ_STATUS, 8'h00);
		$display("interrupt line done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_access();
		t_serial();
		t_timer4();
		t_capcomp();
		t_requests();
		t_irq();
		give_verdict();
	end
endmodule
`default_nettype wire
